// ==== rtl/tap_controller.sv ====
// Test access port controller sampling the tester's clock with the core clock.
`default_nettype none
module tap_controller
    import tap_pkg::*;
#(
    parameter int BSR_BITS = BSR_WIDTH
) (
    // Clock and reset
    input  wire  logic                core_clk,
    input  wire  logic                reset,
    // Serial test pins from the tester
    input  wire  logic                tck,
    input  wire  logic                tms,
    input  wire  logic                tdi,
    output var   logic                tdo,
    output var   logic                tdo_oe,
    // Boundary register parallel input and output
    input  wire  logic [BSR_BITS-1:0] pin_capture,
    output var   logic [BSR_BITS-1:0] pin_drive,
    // Controller status
    output var   logic [IR_WIDTH-1:0] instruction,
    output var   logic                test_reset
);

    // ==========================================================
    // Pin synchronisers
    // Three flops per pin; only the second and third stages are read by logic.
    tap_pins_t sync1;
    tap_pins_t sync2;
    tap_pins_t pins_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1  <= '0;
            sync2  <= '0;
            pins_q <= '0;
        end else begin
            sync1  <= '{tck: tck, tms: tms, tdi: tdi};
            sync2  <= sync1;
            pins_q <= sync2;
        end
    end

    // Edge strobes of the sampled link clock.
    logic tck_rise;
    logic tck_fall;
    assign tck_rise = sync2.tck & ~pins_q.tck;
    assign tck_fall = ~sync2.tck & pins_q.tck;

    // ==========================================================
    // Controller state and data registers
    tap_state_t                state;
    tap_state_t                next_state;
    logic [IR_WIDTH-1:0]       ir_shift;
    logic [IR_WIDTH-1:0]       next_ir_shift;
    logic [IR_WIDTH-1:0]       next_instruction;
    logic [BSR_BITS-1:0]       bsr_shift;
    logic [BSR_BITS-1:0]       next_bsr_shift;
    logic [BSR_BITS-1:0]       next_pin_drive;
    logic                      next_tdo;
    logic                      next_tdo_oe;
    logic                      bsr_selected;

    assign bsr_selected = (instruction == INSTR_EXTEST) || (instruction == INSTR_SAMPLE);

    // Next-state logic, stepped by TMS on each rising link clock edge.
    // The state only moves on the one core cycle that sees the sampled rise.
    // TMS is read from the second synchroniser stage, the same stage that
    // produced the rise strobe, so both belong to one sampled instant.
    // Any state reaches test reset after five high TMS rises through this table.
    always_comb begin
        next_state = state;
        if (tck_rise) begin
            case (state)
                // Test reset is left only when TMS is seen low.
                ST_RESET: begin
                    if (sync2.tms) begin
                        next_state = ST_RESET;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                // Idle waits between scans while TMS is low.
                ST_IDLE: begin
                    if (sync2.tms) begin
                        next_state = ST_SEL_DR;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                // Data branch entry: capture or move on to the instruction branch.
                ST_SEL_DR: begin
                    if (sync2.tms) begin
                        next_state = ST_SEL_IR;
                    end else begin
                        next_state = ST_CAP_DR;
                    end
                end
                // After capture, either shift or skip straight to the exit.
                ST_CAP_DR: begin
                    if (sync2.tms) begin
                        next_state = ST_EXIT1_DR;
                    end else begin
                        next_state = ST_SHIFT_DR;
                    end
                end
                // Data shifting goes on while TMS is low.
                ST_SHIFT_DR: begin
                    if (sync2.tms) begin
                        next_state = ST_EXIT1_DR;
                    end else begin
                        next_state = ST_SHIFT_DR;
                    end
                end
                // First data exit: update or pause.
                ST_EXIT1_DR: begin
                    if (sync2.tms) begin
                        next_state = ST_UPD_DR;
                    end else begin
                        next_state = ST_PAUSE_DR;
                    end
                end
                // Data pause holds the shifter untouched while TMS is low.
                ST_PAUSE_DR: begin
                    if (sync2.tms) begin
                        next_state = ST_EXIT2_DR;
                    end else begin
                        next_state = ST_PAUSE_DR;
                    end
                end
                // Second data exit: update or resume shifting.
                ST_EXIT2_DR: begin
                    if (sync2.tms) begin
                        next_state = ST_UPD_DR;
                    end else begin
                        next_state = ST_SHIFT_DR;
                    end
                end
                // Data update ends the scan.
                ST_UPD_DR: begin
                    if (sync2.tms) begin
                        next_state = ST_SEL_DR;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                // Instruction branch entry: capture or give up to test reset.
                ST_SEL_IR: begin
                    if (sync2.tms) begin
                        next_state = ST_RESET;
                    end else begin
                        next_state = ST_CAP_IR;
                    end
                end
                // After the pattern capture, either shift or skip to the exit.
                ST_CAP_IR: begin
                    if (sync2.tms) begin
                        next_state = ST_EXIT1_IR;
                    end else begin
                        next_state = ST_SHIFT_IR;
                    end
                end
                // Instruction shifting goes on while TMS is low.
                ST_SHIFT_IR: begin
                    if (sync2.tms) begin
                        next_state = ST_EXIT1_IR;
                    end else begin
                        next_state = ST_SHIFT_IR;
                    end
                end
                // First instruction exit: update or pause.
                ST_EXIT1_IR: begin
                    if (sync2.tms) begin
                        next_state = ST_UPD_IR;
                    end else begin
                        next_state = ST_PAUSE_IR;
                    end
                end
                // Instruction pause holds the shifter while TMS is low.
                ST_PAUSE_IR: begin
                    if (sync2.tms) begin
                        next_state = ST_EXIT2_IR;
                    end else begin
                        next_state = ST_PAUSE_IR;
                    end
                end
                // Second instruction exit: update or resume shifting.
                ST_EXIT2_IR: begin
                    if (sync2.tms) begin
                        next_state = ST_UPD_IR;
                    end else begin
                        next_state = ST_SHIFT_IR;
                    end
                end
                // Instruction update ends the scan.
                ST_UPD_IR: begin
                    if (sync2.tms) begin
                        next_state = ST_SEL_DR;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                // An unreachable code falls back to test reset.
                default: begin
                    next_state = ST_RESET;
                end
            endcase
        end
    end

    // Registers in both branches; anything not reset in test reset, captured, shifted or updated holds.
    always_comb begin
        next_ir_shift    = ir_shift;
        next_instruction = instruction;
        next_bsr_shift   = bsr_shift;
        next_pin_drive   = pin_drive;
        next_tdo         = tdo;
        next_tdo_oe      = tdo_oe;
        if (state == ST_RESET) begin
            next_instruction = IR_RESET_VALUE;
        end
        if (tck_rise) begin
            case (state)
                ST_CAP_IR:   next_ir_shift = IR_CAPTURE;
                ST_SHIFT_IR: next_ir_shift = {sync2.tdi, ir_shift[IR_WIDTH-1:1]};
                ST_CAP_DR: begin
                    if (bsr_selected) begin
                        next_bsr_shift = pin_capture;
                    end
                end
                ST_SHIFT_DR: begin
                    if (bsr_selected) begin
                        next_bsr_shift = {sync2.tdi, bsr_shift[BSR_BITS-1:1]};
                    end
                end
                default: begin
                end
            endcase
        end
        if (tck_fall) begin
            // Output changes on the falling edge so the tester samples it cleanly.
            next_tdo_oe = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
            if (state == ST_SHIFT_IR) begin
                next_tdo = ir_shift[0];
            end else if (state == ST_SHIFT_DR) begin
                next_tdo = bsr_selected ? bsr_shift[0] : 1'b0;
            end
            if (state == ST_UPD_IR) begin
                next_instruction = ir_shift;
            end
            if (state == ST_UPD_DR && bsr_selected) begin
                next_pin_drive = bsr_shift;
            end
        end
    end

    // Registers of the controller; five high TMS edges always reach reset via the table.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state       <= ST_RESET;
            ir_shift    <= '0;
            instruction <= IR_RESET_VALUE;
            bsr_shift   <= '0;
            pin_drive   <= '0;
            tdo         <= 1'b0;
            tdo_oe      <= 1'b0;
            test_reset  <= 1'b1;
        end else begin
            state       <= next_state;
            ir_shift    <= next_ir_shift;
            instruction <= next_instruction;
            bsr_shift   <= next_bsr_shift;
            pin_drive   <= next_pin_drive;
            tdo         <= next_tdo;
            tdo_oe      <= next_tdo_oe;
            test_reset  <= (next_state == ST_RESET);
        end
    end

endmodule : tap_controller
`default_nettype wire

// ==== shared/tap_pkg.sv ====
// Package with states, widths, capture pattern and reset values of the test access port.
`default_nettype none
package tap_pkg;
    // ==========================================================
    // Widths and fixed values
    localparam int          IR_WIDTH        = 3;
    localparam int          BSR_WIDTH       = 8;
    localparam logic [2:0]  IR_CAPTURE      = 3'h4;
    localparam logic [2:0]  IR_RESET_VALUE  = 3'h1;
    localparam int          RESET_TMS_EDGES = 5;
    localparam logic [2:0]  INSTR_EXTEST    = 3'h0;
    localparam logic [2:0]  INSTR_SAMPLE    = 3'h2;

    // ==========================================================
    // Controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
        ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_t;

    // Serial link pins from the tester, after synchronisation.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;
endpackage : tap_pkg
`default_nettype wire

// ==== test/tap_controller_props.sv ====
// Checker of the test access port outputs against the serial pins.
`default_nettype none
module tap_controller_props
    import tap_pkg::*;
#(
    parameter int BSR_BITS = BSR_WIDTH
) (
    // Clock and reset
    input wire logic                core_clk,
    input wire logic                reset,
    // Pins of the port
    input wire logic                tck,
    input wire logic                tms,
    input wire logic                tdi,
    input wire logic                tdo,
    input wire logic                tdo_oe,
    input wire logic [BSR_BITS-1:0] pin_capture,
    input wire logic [BSR_BITS-1:0] pin_drive,
    input wire logic [IR_WIDTH-1:0] instruction,
    input wire logic                test_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====================
    // Count of successive tck rises seen with tms high, saturating at seven.
    logic       tck_q;
    logic [2:0] high_cnt;
    logic [2:0] next_high_cnt;
    always_comb begin
        next_high_cnt = high_cnt;
        if (tck && !tck_q) begin
            next_high_cnt = tms ? high_cnt + {2'h0, high_cnt != 3'h7} : 3'h0;
        end
        if (reset) begin
            next_high_cnt = 3'h0;
        end
    end
    // Registers the sampled clock and the count.
    always_ff @(posedge core_clk) begin
        tck_q    <= tck;
        high_cnt <= next_high_cnt;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_five_high: assert property (high_cnt >= 3'h5 |-> ##[0:8] test_reset)
        else $error("test reset missed after five high tms edges");
    a_ir_reset: assert property ($rose(test_reset) |-> ##[0:4] instruction == IR_RESET_VALUE)
        else $error("instruction not reset in test reset");
    a_ir_fall_only: assert property ($changed(instruction) && instruction != IR_RESET_VALUE
        |-> !$past(tck, 2) && !tdo_oe) else $error("instruction changed outside update");
    a_bsr_fall_only: assert property ($changed(pin_drive)
        |-> !$past(tck, 2) && !tdo_oe && !test_reset) else $error("boundary latch moved");
    a_tdo_fall_only: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("tdo changed while tck high");
    a_oe_fall_only: assert property ($changed(tdo_oe) |-> !$past(tck, 2))
        else $error("tdo enable changed while tck high");
    a_oe_off_reset: assert property (test_reset |-> !tdo_oe)
        else $error("tdo enabled in test reset");
    a_reset_values: assert property ($fell(reset) |-> test_reset && !tdo_oe
        && instruction == IR_RESET_VALUE && pin_drive == '0) else $error("bad reset values");
endmodule : tap_controller_props
bind tap_controller tap_controller_props #(.BSR_BITS(BSR_BITS)) props (.core_clk(core_clk),
    .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_capture(pin_capture), .pin_drive(pin_drive), .instruction(instruction),
    .test_reset(test_reset));
`default_nettype wire

// ==== test/tap_tester.sv ====
// Boundary-scan tester model that steps the controller one tck cycle at a time.
`default_nettype none
module tap_tester (
    // Serial pins toward the controller
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock stands low between cycles.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Sets inputs while tck is low, samples tdo at the rise, then lowers tck.
    task automatic step(input logic m, input logic d, output logic [1:0] seen);
        tms <= m;
        tdi <= d;
        #24;
        seen = {tdo_oe, tdo};
        tck <= 1'b1;
        #24;
        tck <= 1'b0;
    endtask : step
endmodule : tap_tester
`default_nettype wire

// ==== test/tap_controller_tb.sv ====
// Self-checking bench for the test access port controller.
`default_nettype none
module tap_controller_tb
    import tap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 core_clk    = 1'b0;
    logic                 reset       = 1'b1;
    logic [BSR_WIDTH-1:0] pin_capture = 8'h3c;
    logic                 tck, tms, tdi, tdo, tdo_oe, test_reset;
    logic [BSR_WIDTH-1:0] pin_drive;
    logic [IR_WIDTH-1:0]  instruction;
    logic [1:0]           seen;
    logic [7:0]           got;
    int                   failures = 0;
    int                   checks = 0;
    // Clock and the two parties.
    always #2.5 core_clk = ~core_clk;
    tap_controller #(.BSR_BITS(BSR_WIDTH)) DUT (.core_clk(core_clk), .reset(reset), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_capture(pin_capture),
        .pin_drive(pin_drive), .instruction(instruction), .test_reset(test_reset));
    tap_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    task automatic check(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
        checks++;
        if (seen_v !== exp_v) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp_v, seen_v);
        end
    endtask : check
    // Steps tms through the low n bits of seq, lowest first, with tdi low.
    task automatic walk(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++) begin
            tester.step(seq[i], 1'b0, seen);
        end
    endtask : walk
    // Loads an instruction, reading the capture pattern and pausing on the way.
    task automatic ir_scan(input logic [2:0] code);
        logic [2:0] was;
        was = instruction;
        walk(8'h03, 4);
        for (int i = 0; i < 3; i++) begin
            tester.step(i == 2, code[i], seen);
            got[i] = seen[0];
            check("tdo_oe", 8'(seen[1]), 8'h01);
        end
        check("capture", 8'(got[2:0]), 8'(IR_CAPTURE));
        walk(8'h04, 3);
        check("held instruction", 8'(instruction), 8'(was));
        walk(8'h01, 2);
        #30;
        check("instruction", 8'(instruction), 8'(code));
    endtask : ir_scan
    // Shifts data through the boundary register and pauses before the update.
    task automatic dr_scan(input logic [7:0] data);
        walk(8'h01, 3);
        for (int i = 0; i < 8; i++) begin
            tester.step(i == 7, data[i], seen);
            got[i] = seen[0];
        end
        check("captured pins", got, pin_capture);
        walk(8'h04, 3);
        check("latch in pause", pin_drive, 8'h00);
        walk(8'h01, 2);
        #30;
        check("latch", pin_drive, data);
    endtask : dr_scan
    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    // Main sequence.
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        check("reset instruction", 8'(instruction), 8'(IR_RESET_VALUE));
        walk(8'h00, 1);
        ir_scan(INSTR_EXTEST);
        dr_scan(8'ha5);
        ir_scan(INSTR_SAMPLE);
        walk(8'h07, 3);
        #30;
        check("select-ir reset", 8'(test_reset), 8'h01);
        walk(8'h02, 4);
        walk(8'h0f, 4);
        #30;
        check("four highs", 8'(test_reset), 8'h00);
        walk(8'h01, 1);
        #30;
        check("five highs", 8'(test_reset), 8'h01);
        walk(8'h02, 4);
        #30;
        check("shift-dr enable", 8'(tdo_oe), 8'h01);
        walk(8'h1f, 5);
        #30;
        check("reset from shift", 8'(test_reset), 8'h01);
        give_verdict();
    end
    // Watchdog against a hang.
    initial begin
        #50000;
        failures++;
        give_verdict();
    end
endmodule : tap_controller_tb
`default_nettype wire
